// >>> uii_pkg.sv
// package: offsets, field positions, codes and timing counts for interrupt identification
package uii_pkg;
    // ************************************************************
    // register map (three-bit address inside the port)
    // ************************************************************
    localparam logic [2:0] ADDR_BUFFER = 3'h0;
    localparam logic [2:0] ADDR_ENABLE = 3'h1;
    localparam logic [2:0] ADDR_IDENT = 3'h2;
    localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
    localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
    localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int EN_RX_BIT = 0;
    localparam int EN_TX_BIT = 1;
    localparam int EN_LS_BIT = 2;
    localparam int EN_MS_BIT = 3;
    localparam int FC_ENABLE_BIT = 0;
    localparam int FC_TRIG_LO = 6;
    localparam int MC_GATE_BIT = 3;
    localparam int LC_DLA_BIT = 7;

    // ************************************************************
    // identification codes, bits three to zero
    // ************************************************************
    localparam logic [3:0] CODE_NONE = 4'h1;
    localparam logic [3:0] CODE_LINE = 4'h6;
    localparam logic [3:0] CODE_DATA = 4'h4;
    localparam logic [3:0] CODE_TIMEOUT = 4'hc;
    localparam logic [3:0] CODE_THRE = 4'h2;
    localparam logic [3:0] CODE_MODEM = 4'h0;

    // ************************************************************
    // reset values and thresholds
    // ************************************************************
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [7:0] IDENT_RST = 8'h01;
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;
    localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

    typedef enum logic [1:0] {UII_SRC_NONE, UII_SRC_LINE, UII_SRC_DATA, UII_SRC_MISC} uii_src_t;
endpackage

// >>> uii_if.sv
// interface: character timer controls between top and timer module
`timescale 1ns/1ps
interface uii_tmr_if;
    logic restart;
    logic armed;
    logic [15:0] char_cycles;
    logic expired;
    modport top (output restart, output armed, output char_cycles, input expired);
    modport tmr (input restart, input armed, input char_cycles, output expired);
endinterface

// >>> uii_char_timer.sv
// module: counts four character times of receive-queue inactivity
`timescale 1ns/1ps
module uii_char_timer (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    uii_tmr_if.tmr tif
);
    logic [15:0] cyc_ff;
    logic [15:0] nxt_cyc;
    logic [2:0] chr_ff;
    logic [2:0] nxt_chr;
    logic exp_ff;
    logic nxt_exp;

    // ************************************************************
    // character-time counter
    // ************************************************************
    // restart or an empty queue drops the count and the flag
    always_comb begin
        nxt_cyc = cyc_ff;
        nxt_chr = chr_ff;
        nxt_exp = exp_ff;
        if (tif.restart || !tif.armed) begin
            nxt_cyc = 16'h0000;
            nxt_chr = 3'h0;
            nxt_exp = 1'b0;
        end else if (chr_ff != uii_pkg::TIMEOUT_CHARS) begin
            if (cyc_ff + 16'h0001 >= tif.char_cycles) begin
                nxt_cyc = 16'h0000;
                nxt_chr = chr_ff + 3'h1;
                nxt_exp = (chr_ff + 3'h1) == uii_pkg::TIMEOUT_CHARS;
            end else begin
                nxt_cyc = cyc_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cyc_ff <= 16'h0000;
            chr_ff <= 3'h0;
            exp_ff <= 1'b0;
        end else begin
            cyc_ff <= nxt_cyc;
            chr_ff <= nxt_chr;
            exp_ff <= nxt_exp;
        end
    end

    assign tif.expired = exp_ff;
endmodule

// >>> uii_ident.sv
// module: interrupt identification, prioritisation and interrupt output of a serial port
//
// Behaviour
// - trigger field selects 1, 4, 8, 14 bytes
// - line, data, transmit, modem priority; report highest
// - code frozen while identification read in progress
// - bit zero low when interrupt pending
// - low nibble codes per interrupt class
// - bit three only timeout in queue mode
// - bits four and five read zero
// - bits six, seven follow queue enable
// - line errors raise; line status read clears
// - data clears on buffer read or below threshold
// - timeout after four idle character times
// - transmit empty clears on ident read while shown, data write
// - modem line changes raise; status read clears
// - enable bits gate each class
// - output gate bit enables interrupt output
`timescale 1ns/1ps
module uii_ident (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host register port
    input wire logic [2:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // receive side
    input wire logic [4:0] rx_level,
    input wire logic rx_push,
    input wire logic line_err,
    // transmit side
    input wire logic thr_empty_rise,
    // modem side
    input wire logic modem_change,
    // frame timing from baud logic
    input wire logic [15:0] char_cycles,
    // interrupt output
    output logic irq,
    output logic irq_oe
);
    logic [7:0] enable_ff;
    logic [7:0] nxt_enable;
    logic [7:0] fifo_ctrl_ff;
    logic [7:0] nxt_fifo_ctrl;
    logic [7:0] modem_ctrl_ff;
    logic [7:0] nxt_modem_ctrl;
    logic dla_ff;
    logic nxt_dla;
    logic ls_ff;
    logic nxt_ls;
    logic thre_ff;
    logic nxt_thre;
    logic ms_ff;
    logic nxt_ms;
    logic rda_ff;
    logic nxt_rda;
    logic to_ff;
    logic nxt_to;
    logic [7:0] ident_ff;
    logic [7:0] nxt_ident;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic irq_ff;
    logic nxt_irq;
    logic oe_ff;
    logic nxt_oe;
    logic fifo_mode;
    logic [4:0] trig;
    logic [3:0] code;
    logic rd_buf;
    logic rd_ident;
    logic rd_ls;
    logic rd_ms;
    logic wr_thr;
    uii_pkg::uii_src_t src;

    uii_tmr_if tif();

    // ************************************************************
    // access decode
    // ************************************************************
    assign fifo_mode = fifo_ctrl_ff[uii_pkg::FC_ENABLE_BIT];
    assign rd_buf = rd && addr == uii_pkg::ADDR_BUFFER && !dla_ff;
    assign wr_thr = wr && addr == uii_pkg::ADDR_BUFFER && !dla_ff;
    assign rd_ident = rd && addr == uii_pkg::ADDR_IDENT;
    assign rd_ls = rd && addr == uii_pkg::ADDR_LINE_STAT;
    assign rd_ms = rd && addr == uii_pkg::ADDR_MODEM_STAT;

    // trigger threshold from the upper control bits
    always_comb begin
        case (fifo_ctrl_ff[uii_pkg::FC_TRIG_LO +: 2])
            2'b00: trig = uii_pkg::TRIG_1;
            2'b01: trig = uii_pkg::TRIG_4;
            2'b10: trig = uii_pkg::TRIG_8;
            2'b11: trig = uii_pkg::TRIG_14;
            default: trig = uii_pkg::TRIG_1;
        endcase
    end

    // ************************************************************
    // character timer
    // ************************************************************
    // any push or pop restarts the idle count
    assign tif.restart = rx_push || rd_buf;
    assign tif.armed = fifo_mode && rx_level != 5'h00;
    assign tif.char_cycles = char_cycles;

    uii_char_timer u_tmr (
        .clk(clk),
        .srst(srst),
        .tif(tif)
    );

    // ************************************************************
    // control registers
    // ************************************************************
    // only the lower nibble of the enable register exists
    always_comb begin
        nxt_enable = enable_ff;
        nxt_fifo_ctrl = fifo_ctrl_ff;
        nxt_modem_ctrl = modem_ctrl_ff;
        nxt_dla = dla_ff;
        if (wr) begin
            case (addr)
                uii_pkg::ADDR_ENABLE: begin
                    if (!dla_ff) begin
                        nxt_enable = {4'h0, wdata[3:0]};
                    end
                end
                uii_pkg::ADDR_IDENT: nxt_fifo_ctrl = {wdata[7:6], 6'h00} | {7'h00, wdata[0]};
                uii_pkg::ADDR_LINE_CTRL: nxt_dla = wdata[uii_pkg::LC_DLA_BIT];
                uii_pkg::ADDR_MODEM_CTRL: nxt_modem_ctrl = {3'h0, wdata[4:0]};
                default: nxt_dla = dla_ff;
            endcase
        end
    end

    // ************************************************************
    // interrupt sources
    // ************************************************************
    // new events win over a clear in the same cycle, except the timeout, where the buffer read wins
    always_comb begin
        nxt_ls = line_err || (ls_ff && !rd_ls);
        nxt_ms = modem_change || (ms_ff && !rd_ms);
        // transmit empty is cleared by an ident read only while it is the shown source
        nxt_thre = thr_empty_rise || (thre_ff && !wr_thr
            && !(rd_ident && ident_ff[3:0] == uii_pkg::CODE_THRE));
        // data available is a level in queue mode, a sticky flag otherwise
        if (fifo_mode) begin
            nxt_rda = rx_level >= trig;
        end else begin
            nxt_rda = rx_push || (rda_ff && !rd_buf);
        end
        // the expired level stands until the read restarts the timer, so the read must win
        nxt_to = fifo_mode && !rd_buf && (tif.expired || to_ff);
    end

    // ************************************************************
    // prioritisation and identification value
    // ************************************************************
    always_comb begin
        src = uii_pkg::UII_SRC_NONE;
        code = uii_pkg::CODE_NONE;
        if (ls_ff && enable_ff[uii_pkg::EN_LS_BIT]) begin
            src = uii_pkg::UII_SRC_LINE;
            code = uii_pkg::CODE_LINE;
        end else if (rda_ff && enable_ff[uii_pkg::EN_RX_BIT]) begin
            src = uii_pkg::UII_SRC_DATA;
            code = uii_pkg::CODE_DATA;
        end else if (to_ff && fifo_mode && enable_ff[uii_pkg::EN_RX_BIT]) begin
            src = uii_pkg::UII_SRC_DATA;
            code = uii_pkg::CODE_TIMEOUT;
        end else if (thre_ff && enable_ff[uii_pkg::EN_TX_BIT]) begin
            src = uii_pkg::UII_SRC_MISC;
            code = uii_pkg::CODE_THRE;
        end else if (ms_ff && enable_ff[uii_pkg::EN_MS_BIT]) begin
            src = uii_pkg::UII_SRC_MISC;
            code = uii_pkg::CODE_MODEM;
        end
        // bit zero low when pending, bits four, five zero, six, seven mode
        nxt_ident = {{2{fifo_mode}}, 2'b00, code};
        // hold the snapshot during a host read of the register
        if (rd_ident) begin
            nxt_ident = ident_ff;
        end
        nxt_irq = src != uii_pkg::UII_SRC_NONE;
        nxt_oe = modem_ctrl_ff[uii_pkg::MC_GATE_BIT];
    end

    // ************************************************************
    // read data
    // ************************************************************
    // unimplemented registers read zero here; the datapath supplies them
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd) begin
            case (addr)
                uii_pkg::ADDR_ENABLE: nxt_rdata = dla_ff ? 8'h00 : enable_ff;
                uii_pkg::ADDR_IDENT: nxt_rdata = ident_ff;
                uii_pkg::ADDR_MODEM_CTRL: nxt_rdata = modem_ctrl_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            enable_ff <= uii_pkg::ENABLE_RST;
            fifo_ctrl_ff <= uii_pkg::FIFO_CTRL_RST;
            modem_ctrl_ff <= uii_pkg::MODEM_CTRL_RST;
            dla_ff <= 1'b0;
            ls_ff <= 1'b0;
            thre_ff <= 1'b0;
            ms_ff <= 1'b0;
            rda_ff <= 1'b0;
            to_ff <= 1'b0;
            ident_ff <= uii_pkg::IDENT_RST;
            rdata_ff <= 8'h00;
            irq_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            enable_ff <= nxt_enable;
            fifo_ctrl_ff <= nxt_fifo_ctrl;
            modem_ctrl_ff <= nxt_modem_ctrl;
            dla_ff <= nxt_dla;
            ls_ff <= nxt_ls;
            thre_ff <= nxt_thre;
            ms_ff <= nxt_ms;
            rda_ff <= nxt_rda;
            to_ff <= nxt_to;
            ident_ff <= nxt_ident;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            oe_ff <= nxt_oe;
        end
    end

    // gated output: irq_oe follows the gate bit one cycle late; irq is driven regardless
    assign rdata = rdata_ff;
    assign irq = irq_ff;
    assign irq_oe = oe_ff;
endmodule

// >>> uii_ident_sva.sv
// checker: assertions on the identification register port
`timescale 1ns/1ps
module uii_sva (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host port
    input wire logic [2:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    // sources and output
    input wire logic line_err,
    input wire logic thr_empty_rise,
    input wire logic modem_change,
    input wire logic irq,
    input wire logic irq_oe
);
    // ********
    // shadow of enables, queue mode and divisor access
    // ********
    logic dla_ff;
    logic fen_ff;
    logic [3:0] en_ff;
    logic nxt_dla;
    logic nxt_fen;
    logic [3:0] nxt_en;
    logic id_rd;
    assign id_rd = rd && addr == uii_pkg::ADDR_IDENT;
    // enable writes under divisor access go to the divisor, not here
    always_comb begin
        nxt_dla = dla_ff;
        nxt_fen = fen_ff;
        nxt_en = en_ff;
        if (wr && addr == uii_pkg::ADDR_LINE_CTRL) nxt_dla = wdata[7];
        if (wr && addr == uii_pkg::ADDR_IDENT) nxt_fen = wdata[0];
        if (wr && addr == uii_pkg::ADDR_ENABLE && !dla_ff) nxt_en = wdata[3:0];
    end
    always_ff @(posedge clk) begin
        dla_ff <= srst ? 1'b0 : nxt_dla;
        fen_ff <= srst ? 1'b0 : nxt_fen;
        en_ff <= srst ? 4'h0 : nxt_en;
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_thre_read;
        id_rd && en_ff == 4'h2 && !thr_empty_rise
        ##1 rdata[3:0] == uii_pkg::CODE_THRE && !thr_empty_rise;
    endsequence
    sequence s_gate_write;
        wr && addr == uii_pkg::ADDR_MODEM_CTRL ##1 !(wr && addr == uii_pkg::ADDR_MODEM_CTRL);
    endsequence
    a_ident_format:
        assert property (id_rd |=> rdata[5:4] == 2'h0 && rdata[0] == (rdata[3:0] == 4'h1))
        else $error("ident format wrong");
    a_timeout_mode:
        assert property (id_rd |=> !rdata[3] || (rdata[2] && rdata[7:6] == 2'h3))
        else $error("ident bit three outside timeout");
    a_mode_bits:
        assert property (id_rd && $stable(fen_ff) |=> rdata[7:6] == {2{$past(fen_ff)}})
        else $error("ident mode bits wrong");
    a_gate_follow:
        assert property (s_gate_write |=> irq_oe == $past(wdata[3], 2))
        else $error("output enable not following gate");
    a_line_irq:
        assert property (line_err && en_ff[uii_pkg::EN_LS_BIT] |-> ##2 irq)
        else $error("line error raised no interrupt");
    a_modem_irq:
        assert property (modem_change && en_ff[uii_pkg::EN_MS_BIT] |-> ##2 irq)
        else $error("modem change raised no interrupt");
    a_mask_all:
        assert property ((en_ff == 4'h0) [*3] |-> !irq)
        else $error("interrupt with all classes masked");
    a_thre_clear:
        assert property (s_thre_read |=> ##1 !irq)
        else $error("transmit empty not cleared by ident read");
    a_read_freeze:
        assert property (id_rd ##1 id_rd |=> $stable(rdata))
        else $error("ident changed during read");
endmodule

bind uii_ident uii_sva CHK (
    .clk(clk), .srst(srst), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata),
    .line_err(line_err), .thr_empty_rise(thr_empty_rise), .modem_change(modem_change),
    .irq(irq), .irq_oe(irq_oe)
);

// >>> uii_host.sv
// partner: host processor model on the register port
`timescale 1ns/1ps
module uii_host (
    // clock
    input wire logic clk,
    // register port
    output logic [2:0] addr,
    output logic rd,
    output logic wr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    // ********
    // bus cycles
    // ********
    initial begin
        addr = 3'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 8'h00;
    end
    // strobe held one cycle so the port takes it at exactly one edge
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d; // released data must not look valid
    endtask
    // one or two back-to-back reads; data taken after the latching edge
    task automatic read_reg(input logic [2:0] a, input int n, output logic [7:0] d0,
            output logic [7:0] d1);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        if (n == 1) rd <= 1'b0;
        #1 d0 = rdata;
        d1 = d0;
        if (n == 2) begin
            @(posedge clk);
            rd <= 1'b0;
            #1 d1 = rdata;
        end
    endtask
endmodule

// >>> tb.sv
// testbench: identification register, priority and interrupt output
`timescale 1ns/1ps
module tb;
    logic clk;
    logic srst;
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] rx_level;
    logic rx_push;
    logic line_err;
    logic thr_empty_rise;
    logic modem_change;
    logic [15:0] char_cycles;
    logic irq;
    logic irq_oe;
    logic [7:0] d0;
    logic [7:0] d1;
    int n_errors = 0;
    int checks_done = 0;
    // row: queue control, enables, events {modem, thre, push, line}, level, ident, irq
    typedef struct packed {logic [7:0] fc; logic [7:0] en; logic [3:0] ev; logic [4:0] lvl;
        logic [7:0] id; logic iq;} uii_row_t;
    uii_row_t rows [14] = '{
        '{8'h00, 8'h0f, 4'h0, 5'h00, 8'h01, 1'b0}, '{8'h00, 8'h0f, 4'hf, 5'h00, 8'h06, 1'b1},
        '{8'h00, 8'h0f, 4'he, 5'h00, 8'h04, 1'b1}, '{8'h00, 8'h0f, 4'hc, 5'h00, 8'h02, 1'b1},
        '{8'h00, 8'h0f, 4'h8, 5'h00, 8'h00, 1'b1}, '{8'h00, 8'h0b, 4'hf, 5'h00, 8'h04, 1'b1},
        '{8'h00, 8'h00, 4'hf, 5'h00, 8'h01, 1'b0}, '{8'h01, 8'h0f, 4'h0, 5'h01, 8'hc4, 1'b1},
        '{8'h41, 8'h0f, 4'h0, 5'h03, 8'hc1, 1'b0}, '{8'h41, 8'h0f, 4'h0, 5'h04, 8'hc4, 1'b1},
        '{8'h81, 8'h0f, 4'h0, 5'h07, 8'hc1, 1'b0}, '{8'h81, 8'h0f, 4'h0, 5'h08, 8'hc4, 1'b1},
        '{8'hc1, 8'h0f, 4'h0, 5'h0d, 8'hc1, 1'b0}, '{8'hc1, 8'h0f, 4'h0, 5'h0e, 8'hc4, 1'b1}};

    uii_ident DUT (
        .clk(clk), .srst(srst), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata),
        .rx_level(rx_level), .rx_push(rx_push), .line_err(line_err),
        .thr_empty_rise(thr_empty_rise), .modem_change(modem_change),
        .char_cycles(char_cycles), .irq(irq), .irq_oe(irq_oe));
    uii_host HOST (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one-cycle pulse on the chosen event inputs
    task automatic pulse(input logic [3:0] ev);
        @(posedge clk);
        {modem_change, thr_empty_rise, rx_push, line_err} <= ev;
        @(posedge clk);
        {modem_change, thr_empty_rise, rx_push, line_err} <= 4'h0;
    endtask
    task automatic ident(input logic [7:0] exp);
        HOST.read_reg(uii_pkg::ADDR_IDENT, 1, d0, d1);
        check("ident", exp, d0);
    endtask
    // drop every sticky source so the next case starts clean
    task automatic flush();
        @(posedge clk);
        rx_level <= 5'h00;
        HOST.read_reg(uii_pkg::ADDR_LINE_STAT, 1, d0, d1);
        HOST.read_reg(uii_pkg::ADDR_BUFFER, 1, d0, d1);
        HOST.read_reg(uii_pkg::ADDR_MODEM_STAT, 1, d0, d1);
        HOST.write_reg(uii_pkg::ADDR_BUFFER, 8'h55);
    endtask
    task automatic cfg(input logic [7:0] fc, input logic [7:0] en);
        HOST.write_reg(uii_pkg::ADDR_IDENT, fc);
        HOST.write_reg(uii_pkg::ADDR_ENABLE, en);
    endtask
    // a hang ends the run as a mismatch
    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        {rx_level, rx_push, line_err, thr_empty_rise, modem_change} = '0;
        char_cycles = 16'h0400;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        #1 check("irq_oe", 8'h00, {7'h0, irq_oe});
        ident(uii_pkg::IDENT_RST);
        HOST.write_reg(uii_pkg::ADDR_MODEM_CTRL, 8'h08);
        repeat (2) @(posedge clk);
        #1 check("irq_oe", 8'h01, {7'h0, irq_oe});
        foreach (rows[i]) begin
            cfg(rows[i].fc, rows[i].en);
            @(posedge clk);
            rx_level <= rows[i].lvl;
            pulse(rows[i].ev);
            repeat (3) @(posedge clk);
            #1 check("irq", {7'h0, rows[i].iq}, {7'h0, irq});
            ident(rows[i].id);
            flush();
            $display("row %0d done", i);
        end
        // new line error lands while the ident is being read twice
        cfg(8'h01, 8'h04);
        // the read starts as the flag lands, so only a frozen snapshot reads 0xc1 twice
        fork
            begin
                @(posedge clk);
                HOST.read_reg(uii_pkg::ADDR_IDENT, 2, d0, d1);
            end
            pulse(4'h1);
        join
        check("frozen ident", 8'hc1, d1);
        ident(8'hc6);
        HOST.read_reg(uii_pkg::ADDR_LINE_STAT, 1, d0, d1);
        ident(8'hc1);
        $display("freeze done");
        // short character time: idle queue below threshold times out
        @(posedge clk);
        char_cycles <= 16'h0004;
        cfg(8'hc1, 8'h01);
        @(posedge clk);
        rx_level <= 5'h01;
        for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk);
        check("timeout irq", 8'h01, {7'h0, irq});
        if (irq !== 1'b1) end_of_test();
        ident(8'hcc);
        HOST.read_reg(uii_pkg::ADDR_BUFFER, 1, d0, d1);
        ident(8'hc1);
        flush();
        char_cycles <= 16'h0400;
        $display("timeout done");
        cfg(8'h00, 8'h02);
        pulse(4'h4);
        ident(8'h02);
        ident(8'h01);
        pulse(4'h4);
        HOST.write_reg(uii_pkg::ADDR_BUFFER, 8'ha5);
        ident(8'h01);
        HOST.write_reg(uii_pkg::ADDR_ENABLE, 8'h08);
        pulse(4'h8);
        ident(8'h00);
        HOST.read_reg(uii_pkg::ADDR_MODEM_STAT, 1, d0, d1);
        ident(8'h01);
        $display("clear paths done");
        // enable write under divisor access must not land
        HOST.write_reg(uii_pkg::ADDR_ENABLE, 8'h00);
        HOST.write_reg(uii_pkg::ADDR_LINE_CTRL, 8'h80);
        HOST.write_reg(uii_pkg::ADDR_ENABLE, 8'h04);
        HOST.write_reg(uii_pkg::ADDR_LINE_CTRL, 8'h00);
        pulse(4'h1);
        ident(8'h01);
        flush();
        HOST.write_reg(uii_pkg::ADDR_MODEM_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        #1 check("irq_oe", 8'h00, {7'h0, irq_oe});
        $display("gate done");
        end_of_test();
    end
endmodule
